// file: design/mrp_pkg.sv
// package: register map, field layout and region lookup helpers
`default_nettype none
package mrp_pkg;
	// ========================================
	// region count and register offsets
	localparam int unsigned MRP_MAX_REGIONS = 8;
	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_ICACHE     = 8'h04;
	localparam logic [7:0]  ADDR_DCACHE     = 8'h08;
	localparam logic [7:0]  ADDR_DBUF       = 8'h0c;
	localparam logic [7:0]  ADDR_IPERM      = 8'h10;
	localparam logic [7:0]  ADDR_DPERM      = 8'h14;
	localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h18;
	localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h1c;
	localparam logic [7:0]  ADDR_FAULT_ADDR = 8'h20;
	localparam logic [7:0]  ADDR_REGION0    = 8'h40;
	// ========================================
	// field positions
	localparam int unsigned CTRL_EN_BIT     = 0;
	localparam int unsigned REG_VALID_BIT   = 0;
	localparam int unsigned REG_SIZE_LSB    = 1;
	localparam int unsigned REG_BASE_LSB    = 12;
	localparam int unsigned EVT_DABT        = 0;
	localparam int unsigned EVT_PABT        = 1;
	localparam int unsigned EVT_NOMAP       = 2;
	localparam int unsigned EVT_W           = 3;
	localparam logic [4:0]  SIZE_MIN        = 5'h0b;
	// ========================================
	// permission codes
	localparam logic [3:0]  PERM_NONE       = 4'h0;
	localparam logic [3:0]  PERM_PRIV_RW    = 4'h1;
	localparam logic [3:0]  PERM_PRIV_USR_RO = 4'h2;
	localparam logic [3:0]  PERM_FULL       = 4'h3;
	localparam logic [3:0]  PERM_PRIV_RO    = 4'h5;
	localparam logic [3:0]  PERM_ALL_RO     = 4'h6;
	// ========================================
	// reset values
	localparam logic [7:0]  RST_ATTR        = 8'h00;
	localparam logic [31:0] RST_WORD        = 32'h0000_0000;
	localparam logic [2:0]  RST_EVT         = 3'h0;
	// ========================================
	// types and helpers
	typedef struct packed {
		logic [19:0] base;
		logic [4:0]  size;
		logic        valid;
	} mrp_region_s;
	typedef mrp_region_s [MRP_MAX_REGIONS-1:0] mrp_region_t;

	function automatic logic mrp_region_hit(input logic [31:0] addr, input mrp_region_s r);
		logic [32:0] span;
		logic [32:0] low;
		logic [31:0] keep;
		span = 33'h1 << ({1'b0, r.size} + 6'h01);
		low  = span - 33'h1;
		keep = ~low[31:0];
		return r.valid && (r.size >= SIZE_MIN) &&
			((addr & keep) == ({r.base, 12'h000} & keep));
	endfunction

	function automatic logic [3:0] mrp_nibble(input logic [31:0] w, input logic [2:0] i);
		return w[{i, 2'b00} +: 4];
	endfunction
endpackage
`default_nettype wire

// file: design/mrp_lookup_if.sv
// interface: one side's region lookup and permission check
`default_nettype none
interface mrp_lookup_if;
	logic [31:0] addr;
	logic        priv;
	logic        write;
	logic [7:0]  hits;
	logic        hit;
	logic [2:0]  idx;
	logic [3:0]  perm;
	logic        allow;
	modport sel (input addr, output hits, output hit, output idx);
	modport chk (input perm, input priv, input write, output allow);
	modport top (output addr, output priv, output write, output perm,
		input hits, input hit, input idx, input allow);
endinterface
`default_nettype wire

// file: design/mrp_region_sel.sv
// region matcher with fixed priority, highest index wins
`default_nettype none
module mrp_region_sel #(
	parameter int unsigned NUM_REGIONS = 8
) (
	// region table
	input  wire mrp_pkg::mrp_region_t regions,
	// lookup
	mrp_lookup_if.sel                 lk
);
	import mrp_pkg::*;

	// ========================================
	// elaboration check
	if (NUM_REGIONS < 1 || NUM_REGIONS > MRP_MAX_REGIONS) begin : g_bad_count
		$error("NUM_REGIONS must be 1 to 8");
	end

	// ========================================
	// match and priority
	always_comb begin
		lk.hits = 8'h00;
		lk.hit  = 1'b0;
		lk.idx  = 3'h0;
		for (int i = 0; i < NUM_REGIONS; i++) begin
			lk.hits[i] = mrp_region_hit(lk.addr, regions[i]);
			if (lk.hits[i]) begin
				lk.hit = 1'b1;
				lk.idx = 3'(i);
			end
		end
	end
endmodule
`default_nettype wire

// file: design/mrp_perm_chk.sv
// permission code decode for one access
`default_nettype none
module mrp_perm_chk (
	// lookup
	mrp_lookup_if.chk lk
);
	import mrp_pkg::*;

	// ========================================
	// decode
	always_comb begin
		case (lk.perm)
			PERM_NONE:        lk.allow = 1'b0;
			PERM_PRIV_RW:     lk.allow = lk.priv;
			PERM_PRIV_USR_RO: lk.allow = lk.priv || !lk.write;
			PERM_FULL:        lk.allow = 1'b1;
			PERM_PRIV_RO:     lk.allow = lk.priv && !lk.write;
			PERM_ALL_RO:      lk.allow = !lk.write;
			default:          lk.allow = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// file: design/mrp_top.sv
// memory region protection unit: registers, lookup and abort logic
//
// The strobed register port and the placing of the registers are this design's own decisions.
`default_nettype none
// Function
// - Up to eight regions, each with its own size.
// - Checking is active only while control bit 0 is one.
// - Disabled: fetches noncacheable, data noncacheable and nonbufferable.
// - Each region holds base, size, cache attributes and permissions.
// - Five-bit size field encodes 4 Kbytes up to 4 Gbytes.
// - Cacheable and permissions for all; bufferable only on data side.
// - Failed check gives prefetch abort for fetch, data abort for data.
// - Cacheable and bufferable form a two-bit behaviour select.
// - Highest-numbered hit region decides on overlap.
// - Enabled access that hits no region is aborted.
// - Code 0010 priv full, user read; 0001 privileged only.
// - User write to user read-only region aborts; user read allowed.
module mrp_top #(
	parameter int unsigned NUM_REGIONS = 8
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// instruction side
	input  wire logic        ins_req,
	input  wire logic [31:0] ins_addr,
	input  wire logic        ins_priv,
	output logic             ins_abort,
	output logic             ins_cacheable,
	// data side
	input  wire logic        dat_req,
	input  wire logic [31:0] dat_addr,
	input  wire logic        dat_write,
	input  wire logic        dat_priv,
	output logic             dat_abort,
	output logic             dat_cacheable,
	output logic             dat_bufferable,
	output logic      [1:0]  dat_cb,
	// interrupt
	output logic             irq
);
	import mrp_pkg::*;

	// ========================================
	// elaboration check
	if (NUM_REGIONS < 1 || NUM_REGIONS > MRP_MAX_REGIONS) begin : g_bad_count
		$error("NUM_REGIONS must be 1 to 8");
	end

	// ========================================
	// declarations
	logic              ctrl_en_r;
	logic [7:0]        icache_r;
	logic [7:0]        dcache_r;
	logic [7:0]        dbuf_r;
	logic [31:0]       iperm_r;
	logic [31:0]       dperm_r;
	logic [EVT_W-1:0]  irq_stat_r;
	logic [EVT_W-1:0]  irq_stat_nxt;
	logic [EVT_W-1:0]  irq_mask_r;
	logic [EVT_W-1:0]  evt;
	logic [31:0]       fault_addr_r;
	logic [31:0]       reg_rdata_r;
	logic [31:0]       rd_nxt;
	mrp_region_t       region_r;
	logic              sel_region;
	logic [2:0]        region_idx;
	logic              ins_fail;
	logic              dat_fail;

	mrp_lookup_if ilk ();
	mrp_lookup_if dlk ();

	// ========================================
	// register decode
	always_comb begin
		region_idx = reg_addr[4:2];
		sel_region = (reg_addr[7:5] == ADDR_REGION0[7:5]) && (reg_addr[1:0] == 2'b00) &&
			({29'h0, region_idx} < NUM_REGIONS);
	end

	// ========================================
	// control register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_en_r <= 1'b0;
		end else if (reg_wr && reg_addr == ADDR_CTRL) begin
			ctrl_en_r <= reg_wdata[CTRL_EN_BIT];
		end
	end

	// ========================================
	// attribute and permission registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			icache_r <= RST_ATTR;
			dcache_r <= RST_ATTR;
			dbuf_r   <= RST_ATTR;
			iperm_r  <= RST_WORD;
			dperm_r  <= RST_WORD;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_ICACHE: icache_r <= reg_wdata[7:0];
				ADDR_DCACHE: dcache_r <= reg_wdata[7:0];
				ADDR_DBUF:   dbuf_r   <= reg_wdata[7:0];
				ADDR_IPERM:  iperm_r  <= reg_wdata;
				ADDR_DPERM:  dperm_r  <= reg_wdata;
				default: ;
			endcase
		end
	end

	// ========================================
	// region table
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			region_r <= '0;
		// base, size and valid per region
		end else if (reg_wr && sel_region) begin
			region_r[region_idx].base  <= reg_wdata[31:REG_BASE_LSB];
			region_r[region_idx].size  <= reg_wdata[REG_SIZE_LSB +: 5];
			region_r[region_idx].valid <= reg_wdata[REG_VALID_BIT];
		end
	end

	// ========================================
	// lookups
	// one matcher per side over all regions
	mrp_region_sel #(
		.NUM_REGIONS (NUM_REGIONS)
	) u_isel (
		.regions (region_r),
		.lk      (ilk.sel)
	);

	mrp_region_sel #(
		.NUM_REGIONS (NUM_REGIONS)
	) u_dsel (
		.regions (region_r),
		.lk      (dlk.sel)
	);

	mrp_perm_chk u_ichk (
		.lk (ilk.chk)
	);

	mrp_perm_chk u_dchk (
		.lk (dlk.chk)
	);

	always_comb begin
		ilk.addr  = ins_addr;
		ilk.priv  = ins_priv;
		ilk.write = 1'b0;
		dlk.addr  = dat_addr;
		dlk.priv  = dat_priv;
		dlk.write = dat_write;
	end

	// matched region picks its permission nibble
	always_comb begin
		ilk.perm = mrp_nibble(iperm_r, ilk.idx);
		dlk.perm = mrp_nibble(dperm_r, dlk.idx);
	end

	// ========================================
	// access results
	always_comb begin
		ins_fail = !ilk.hit || !ilk.allow;
		dat_fail = !dlk.hit || !dlk.allow;
		ins_abort = ctrl_en_r && ins_req && ins_fail;
		dat_abort = ctrl_en_r && dat_req && dat_fail;
		ins_cacheable  = ctrl_en_r && ilk.hit && icache_r[ilk.idx];
		dat_cacheable  = ctrl_en_r && dlk.hit && dcache_r[dlk.idx];
		dat_bufferable = ctrl_en_r && dlk.hit && dbuf_r[dlk.idx];
		dat_cb = {dat_cacheable, dat_bufferable};
	end

	// ========================================
	// events and interrupt
	always_comb begin
		evt = '0;
		evt[EVT_DABT]  = dat_abort;
		evt[EVT_PABT]  = ins_abort;
		evt[EVT_NOMAP] = (dat_abort && !dlk.hit) || (ins_abort && !ilk.hit);
		irq_stat_nxt = irq_stat_r;
		if (reg_wr && reg_addr == ADDR_IRQ_STAT) begin
			irq_stat_nxt = irq_stat_nxt & ~reg_wdata[EVT_W-1:0];
		end
		irq_stat_nxt = irq_stat_nxt | evt;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_r <= RST_EVT;
		end else begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_r <= RST_EVT;
		end else if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
			irq_mask_r <= reg_wdata[EVT_W-1:0];
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// ========================================
	// fault address capture, data side first
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_addr_r <= RST_WORD;
		end else if (dat_abort) begin
			fault_addr_r <= dat_addr;
		end else if (ins_abort) begin
			fault_addr_r <= ins_addr;
		end
	end

	// ========================================
	// read back
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (sel_region) begin
			rd_nxt = {region_r[region_idx].base, 6'h00, region_r[region_idx].size,
				region_r[region_idx].valid};
		end else begin
			case (reg_addr)
				ADDR_CTRL:       rd_nxt = {31'h0, ctrl_en_r};
				ADDR_ICACHE:     rd_nxt = {24'h0, icache_r};
				ADDR_DCACHE:     rd_nxt = {24'h0, dcache_r};
				ADDR_DBUF:       rd_nxt = {24'h0, dbuf_r};
				ADDR_IPERM:      rd_nxt = iperm_r;
				ADDR_DPERM:      rd_nxt = dperm_r;
				ADDR_IRQ_STAT:   rd_nxt = {29'h0, irq_stat_r};
				ADDR_IRQ_MASK:   rd_nxt = {29'h0, irq_mask_r};
				ADDR_FAULT_ADDR: rd_nxt = fault_addr_r;
				default:         rd_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_r <= RST_WORD;
		end else if (reg_rd) begin
			reg_rdata_r <= rd_nxt;
		end else begin
			reg_rdata_r <= RST_WORD;
		end
	end

	assign reg_rdata = reg_rdata_r;

	// ========================================
	// assertions
	default clocking cb_core @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_en_write;
		(reg_wr && reg_addr == ADDR_CTRL) |=> (ctrl_en_r == $past(reg_wdata[0]));
	endproperty
	a_en_write: assert property (p_en_write)
		else $error("enable bit did not follow control write");

	property p_dis_attr;
		!ctrl_en_r |-> (!ins_cacheable && !dat_cacheable && !dat_bufferable &&
			!ins_abort && !dat_abort);
	endproperty
	a_dis_attr: assert property (p_dis_attr)
		else $error("attribute or abort seen while disabled");

	property p_nomap;
		(ctrl_en_r && dat_req && !dlk.hit) |-> dat_abort ##1 irq_stat_r[EVT_NOMAP];
	endproperty
	a_nomap: assert property (p_nomap)
		else $error("unmapped data access not aborted and flagged");

	property p_pabt;
		(ins_req && ins_abort) |=> irq_stat_r[EVT_PABT];
	endproperty
	a_pabt: assert property (p_pabt)
		else $error("prefetch abort not recorded");

	property p_top_wins;
		dlk.hits[7] |-> (dlk.idx == 3'h7);
	endproperty
	a_top_wins: assert property (p_top_wins)
		else $error("region seven hit but lower region chosen");

	property p_usr_wr;
		(ctrl_en_r && dat_req && dat_write && !dat_priv && dlk.hit &&
			mrp_nibble(dperm_r, dlk.idx) == PERM_PRIV_USR_RO) |-> dat_abort;
	endproperty
	a_usr_wr: assert property (p_usr_wr)
		else $error("user write to read-only region not aborted");

	property p_usr_rd;
		(ctrl_en_r && dat_req && !dat_write && dlk.hit &&
			mrp_nibble(dperm_r, dlk.idx) == PERM_PRIV_USR_RO) |-> !dat_abort;
	endproperty
	a_usr_rd: assert property (p_usr_rd)
		else $error("read of user read-only region aborted");

	property p_priv_only;
		(ctrl_en_r && dat_req && !dat_priv && dlk.hit &&
			mrp_nibble(dperm_r, dlk.idx) == PERM_PRIV_RW) |-> dat_abort;
	endproperty
	a_priv_only: assert property (p_priv_only)
		else $error("user access to privileged region not aborted");

	property p_cb_sel;
		(ctrl_en_r && dlk.hit) |-> (dat_cb == {dcache_r[dlk.idx], dbuf_r[dlk.idx]});
	endproperty
	a_cb_sel: assert property (p_cb_sel)
		else $error("behaviour select differs from region bits");

	property p_irq_level;
		(irq_stat_nxt[EVT_DABT] && irq_mask_r[EVT_DABT] && !reg_wr) |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("masked-in data abort gave no interrupt");
endmodule
`default_nettype wire

// file: verif/mrp_core_model.sv
// partner model: processor core fetch and data request side
`default_nettype none
module mrp_core_model (
	// clock
	input  wire logic        core_clk,
	// instruction side
	output logic             ins_req,
	output logic      [31:0] ins_addr,
	output logic             ins_priv,
	// data side
	output logic             dat_req,
	output logic      [31:0] dat_addr,
	output logic             dat_write,
	output logic             dat_priv
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		ins_req   = 1'b0;
		ins_addr  = 32'h0000_0000;
		ins_priv  = 1'b0;
		dat_req   = 1'b0;
		dat_addr  = 32'h0000_0000;
		dat_write = 1'b0;
		dat_priv  = 1'b0;
	end

	// ========================================
	// released side shows inverted address
	task automatic idle();
		@(posedge core_clk);
		ins_req  <= 1'b0;
		dat_req  <= 1'b0;
		ins_addr <= ~ins_addr;
		dat_addr <= ~dat_addr;
		#1;
	endtask

	task automatic fetch(input logic [31:0] a, input logic p);
		@(posedge core_clk);
		ins_req  <= 1'b1;
		ins_addr <= a;
		ins_priv <= p;
		dat_req  <= 1'b0;
		dat_addr <= ~dat_addr;
		#1;
	endtask

	task automatic access(input logic [31:0] a, input logic w, input logic p);
		@(posedge core_clk);
		dat_req   <= 1'b1;
		dat_addr  <= a;
		dat_write <= w;
		dat_priv  <= p;
		ins_req   <= 1'b0;
		ins_addr  <= ~ins_addr;
		#1;
	endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// testbench: register programming and access checks of the protection unit
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import mrp_pkg::*;

	logic        core_clk;
	logic        rst_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        ins_req;
	logic [31:0] ins_addr;
	logic        ins_priv;
	logic        ins_abort;
	logic        ins_cacheable;
	logic        dat_req;
	logic [31:0] dat_addr;
	logic        dat_write;
	logic        dat_priv;
	logic        dat_abort;
	logic        dat_cacheable;
	logic        dat_bufferable;
	logic [1:0]  dat_cb;
	logic        irq;
	int          miscompares;
	int          comparisons;

	mrp_top #(.NUM_REGIONS(8)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ins_req(ins_req), .ins_addr(ins_addr),
		.ins_priv(ins_priv), .ins_abort(ins_abort), .ins_cacheable(ins_cacheable),
		.dat_req(dat_req), .dat_addr(dat_addr), .dat_write(dat_write),
		.dat_priv(dat_priv), .dat_abort(dat_abort), .dat_cacheable(dat_cacheable),
		.dat_bufferable(dat_bufferable), .dat_cb(dat_cb), .irq(irq)
	);

	mrp_core_model core_u (
		.core_clk(core_clk), .ins_req(ins_req), .ins_addr(ins_addr),
		.ins_priv(ins_priv), .dat_req(dat_req), .dat_addr(dat_addr),
		.dat_write(dat_write), .dat_priv(dat_priv)
	);

	// ========================================
	// clock, watchdog and shared tasks
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		results();
	end

	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	task automatic dchk(input logic [31:0] a, input logic w, input logic p,
		input logic ab, input logic [1:0] cb);
		core_u.access(a, w, p);
		chk({27'h0, dat_abort, dat_cacheable, dat_bufferable, dat_cb},
			{27'h0, ab, cb, cb});
	endtask

	task automatic ichk(input logic [31:0] a, input logic p, input logic ab,
		input logic c);
		core_u.fetch(a, p);
		chk({30'h0, ins_abort, ins_cacheable}, {30'h0, ab, c});
	endtask

	// ========================================
	// main sequence
	initial begin
		miscompares = 0;
		comparisons = 0;
		rst_n       = 1'b0;
		reg_addr    = 8'h00;
		reg_wdata   = 32'h0000_0000;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		rchk(ADDR_CTRL, RST_WORD);
		rchk(ADDR_IRQ_STAT, RST_WORD);
		wr(ADDR_REGION0 + 8'h04, 32'h0000_001b);
		wr(ADDR_REGION0 + 8'h08, 32'h0000_3017);
		wr(ADDR_DPERM, 32'h0000_0210);
		wr(ADDR_IPERM, 32'h0000_0030);
		wr(ADDR_DCACHE, 32'h0000_0006);
		wr(ADDR_DBUF, 32'h0000_0004);
		wr(ADDR_ICACHE, 32'h0000_0002);
		rchk(ADDR_REGION0 + 8'h08, 32'h0000_3017);
		dchk(32'h0000_3010, 1'b1, 1'b0, 1'b0, 2'b00);
		ichk(32'h0000_1000, 1'b0, 1'b0, 1'b0);
		wr(ADDR_CTRL, 32'h0000_0001);
		dchk(32'h0000_3010, 1'b0, 1'b0, 1'b0, 2'b11);
		dchk(32'h0000_3010, 1'b1, 1'b0, 1'b1, 2'b11);
		dchk(32'h0000_3010, 1'b1, 1'b1, 1'b0, 2'b11);
		dchk(32'h0000_1000, 1'b0, 1'b0, 1'b1, 2'b10);
		dchk(32'h0000_1000, 1'b1, 1'b1, 1'b0, 2'b10);
		dchk(32'h0000_4000, 1'b0, 1'b1, 1'b1, 2'b00);
		ichk(32'h0000_1000, 1'b0, 1'b0, 1'b1);
		ichk(32'h0000_4000, 1'b1, 1'b1, 1'b0);
		ichk(32'h0000_3010, 1'b1, 1'b1, 1'b0);
		core_u.idle();
		rchk(ADDR_IRQ_STAT, 32'h0000_0007);
		rchk(ADDR_FAULT_ADDR, 32'h0000_3010);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(ADDR_IRQ_MASK, 32'h0000_0004);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(ADDR_IRQ_STAT, 32'h0000_0004);
		chk({31'h0, irq}, 32'h0000_0000);
		rchk(ADDR_IRQ_STAT, 32'h0000_0003);
		rchk(8'hfc, 32'h0000_0000);
		wr(ADDR_REGION0, 32'h0000_003f);
		wr(ADDR_DPERM, 32'h3000_0213);
		dchk(32'h8000_0000, 1'b1, 1'b0, 1'b0, 2'b00);
		dchk(32'h0000_3010, 1'b1, 1'b0, 1'b1, 2'b11);
		// abort stands: mask in, then clear loses to set
		wr(ADDR_IRQ_MASK, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(ADDR_IRQ_STAT, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(ADDR_REGION0 + 8'h1c, 32'h0000_3017);
		dchk(32'h0000_3010, 1'b1, 1'b0, 1'b0, 2'b00);
		// read-only codes for privileged and all
		wr(ADDR_DPERM, 32'h3000_0256);
		dchk(32'h0000_1000, 1'b1, 1'b1, 1'b1, 2'b10);
		dchk(32'h0000_1000, 1'b0, 1'b1, 1'b0, 2'b10);
		dchk(32'h8000_0000, 1'b1, 1'b1, 1'b1, 2'b00);
		wr(ADDR_CTRL, 32'h0000_0000);
		dchk(32'h0000_1000, 1'b0, 1'b0, 1'b0, 2'b00);
		ichk(32'h0000_1000, 1'b0, 1'b0, 1'b0);
		results();
	end
endmodule
`default_nettype wire
